//--- include/fasr_pkg.sv
/*
 Package for the fault alert status register block: register offsets,
 field positions, reset values, oscillator check timing and FSM states.
 Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package fasr_pkg;

   // Register byte offsets
   localparam logic [7:0] FASR_OFS_ALERT = 8'h00;
   localparam logic [7:0] FASR_OFS_CTRL = 8'h04;
   localparam logic [7:0] FASR_OFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] FASR_OFS_IRQ_MASK = 8'h0C;
   localparam logic [7:0] FASR_OFS_BALSW = 8'h10;
   localparam logic [7:0] FASR_OFS_OSC_COUNT = 8'h14;

   // Fields of fault_alert_status_1
   localparam int FASR_BIT_SLOW_OSC = 15;
   localparam int FASR_BIT_SLOW_OSC_RED = 14;
   localparam int FASR_BIT_UPPER_SE = 13;
   localparam int FASR_BIT_LOWER_SE = 12;
   localparam int FASR_BIT_UPPER_SE_RED = 11;
   localparam int FASR_BIT_LOWER_SE_RED = 10;
   localparam int FASR_BIT_SUPPLY_LSB = 7;
   localparam int FASR_BIT_GROUND_LSB = 4;
   localparam int FASR_BIT_HV_UV = 3;
   localparam int FASR_BIT_HV_HEADROOM = 2;
   localparam int FASR_BIT_HV_OV = 1;
   localparam int FASR_BIT_BALSW_SUM = 0;
   localparam int FASR_BIT_ALERT_RESET = 0;
   localparam int FASR_ALERT_W = 16;
   localparam int FASR_BALSW_N = 14;

   // Bits that a zero write may clear; the single-ended bits are read only
   localparam logic [15:0] FASR_ALERT_W0C_MASK = 16'hC3FF;
   localparam logic [15:0] FASR_ALERT_RESET_VAL = 16'h0000;
   localparam logic [15:0] FASR_IRQ_MASK_RESET_VAL = 16'h0000;
   localparam logic FASR_ALERT_RESET_FLAG_RESET_VAL = 1'b1;

   localparam logic [1:0] FASR_RESP_OKAY = 2'b00;
   localparam logic [1:0] FASR_RESP_SLVERR = 2'b10;

   // Slow oscillator check, measured on aclk
   localparam int FASR_CLK_HZ = 200_000_000;
   localparam int FASR_SLOW_OSC_HZ = 32_768;
   localparam int FASR_OSC_WINDOW_PERIODS = 2;
   localparam int FASR_OSC_TOL_PCT = 5;
   localparam int FASR_OSC_EXPECT_CYCLES =
      FASR_CLK_HZ / FASR_SLOW_OSC_HZ * FASR_OSC_WINDOW_PERIODS;

   typedef enum logic [1:0]
   {
      FASR_OSC_WAIT = 2'b01,
      FASR_OSC_COUNT = 2'b10
   } fasr_osc_state_t;

endpackage

//--- include/fasr_sticky_if.sv
/*
 Interface carrying set, clear and state of a bank of sticky bits.
 Assumes the owner of the bits and its user share one clock.
*/
`timescale 1ns/100ps
interface fasr_sticky_if #(parameter int W = 16);
   logic [W-1:0] set;
   logic [W-1:0] clr;
   logic [W-1:0] q;

   modport bank
   (
      input set,
      input clr,
      output q
   );

   modport user
   (
      output set,
      output clr,
      input q
   );
endinterface

//--- rtl/fasr_sticky_bank.sv
/*
 Bank of sticky bits: each bit sets on its set input and holds until cleared.
 Assumes set and clear come from logic on aclk.
*/
`timescale 1ns/100ps
module fasr_sticky_bank
   import fasr_pkg::*;
#(
   parameter int W = 16,
   parameter logic [W-1:0] RESET_VAL = '0
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   fasr_sticky_if.bank bits
);

   logic [W-1:0] next_q;

   // Set beats a simultaneous clear so no event is lost
   always_comb
   begin
      next_q = (bits.q & ~bits.clr) | bits.set;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         bits.q <= RESET_VAL;
      else if (ce)
         bits.q <= next_q;
   end

endmodule

//--- rtl/fasr_top.sv
/*
 Fault alert status register with AXI4-Lite access, slow oscillator check,
 interrupt status and mask. Assumes the monitor conditions arrive
 asynchronously, while scan and acquisition signals come from aclk logic.
*/
`timescale 1ns/100ps
// Operation
// - Bit 15 latches slow oscillator deviation, zero-clear.
// - Oscillator status re-evaluated every two slow periods.
// - Bit 14 independent latch of same fault.
// - Bit 13 upper single-ended, gated by reset flag.
// - Bit 12 lower single-ended, gated by reset flag.
// - Bit 11 upper single-ended, never gated.
// - Bit 10 lower single-ended, never gated.
// - Bits 9..7 supply faults, gated, zero-clear.
// - Bits 6..4 open ground faults, gated, zero-clear.
// - Bit 3 HV undervoltage, gated, zero-clear.
// - Bit 2 headroom fault only during acquisition.
// - Bit 1 HV overvoltage, gated, zero-clear.
// - Bit 0 ORs balance alerts at scan end.
// - Bit 0 auto-clears when resolved or zero-written.
module fasr_top
   import fasr_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int OSC_EXPECT_CYCLES = FASR_OSC_EXPECT_CYCLES
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic slow_osc_in,
   input wire logic upper_port_single_ended,
   input wire logic lower_port_single_ended,
   input wire logic [2:0] low_supply_under,
   input wire logic [2:0] ground_open,
   input wire logic hv_under,
   input wire logic hv_headroom_low,
   input wire logic hv_over,
   input wire logic acq_active,
   input wire logic [FASR_BALSW_N-1:0] balance_switch_fault,
   input wire logic balance_switch_diag_scan_done,
   output logic [FASR_ALERT_W-1:0] fault_alert_status_1,
   output logic irq
);

   localparam int OSC_TOL = OSC_EXPECT_CYCLES * FASR_OSC_TOL_PCT / 100;
   localparam int OSC_LO = OSC_EXPECT_CYCLES - OSC_TOL;
   localparam int OSC_HI = OSC_EXPECT_CYCLES + OSC_TOL;
   localparam int OSC_CNT_W = $clog2(OSC_HI + 2);
   localparam int SYNC_W = 12;

   // Two-stage synchronisers for the monitor inputs
   logic [SYNC_W-1:0] sync1;
   logic [SYNC_W-1:0] sync2;
   logic [SYNC_W-1:0] next_sync1;
   logic [SYNC_W-1:0] next_sync2;
   logic slow_osc_s;
   logic upper_se_s;
   logic lower_se_s;
   logic [2:0] supply_s;
   logic [2:0] ground_s;
   logic hv_under_s;
   logic headroom_s;
   logic hv_over_s;

   always_comb
   begin
      next_sync1 = {slow_osc_in, upper_port_single_ended, lower_port_single_ended,
                    low_supply_under, ground_open, hv_under, hv_headroom_low, hv_over};
      next_sync2 = sync1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1 <= '0;
         sync2 <= '0;
      end
      else if (ce)
      begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
      end
   end

   assign {slow_osc_s, upper_se_s, lower_se_s, supply_s, ground_s,
           hv_under_s, headroom_s, hv_over_s} = sync2;

   // Slow oscillator check: count aclk cycles over two slow periods
   fasr_osc_state_t osc_state;
   fasr_osc_state_t next_osc_state;
   logic [OSC_CNT_W-1:0] osc_cnt;
   logic [OSC_CNT_W-1:0] next_osc_cnt;
   logic [OSC_CNT_W-1:0] osc_last;
   logic [OSC_CNT_W-1:0] next_osc_last;
   logic osc_half;
   logic next_osc_half;
   logic osc_prev;
   logic osc_fault;
   logic next_osc_fault;
   logic osc_edge;

   assign osc_edge = slow_osc_s & ~osc_prev;

   always_comb
   begin
      next_osc_state = osc_state;
      next_osc_cnt = osc_cnt;
      next_osc_last = osc_last;
      next_osc_half = osc_half;
      next_osc_fault = osc_fault;
      case (osc_state)
         FASR_OSC_WAIT:
         begin
            if (osc_edge)
            begin
               next_osc_state = FASR_OSC_COUNT;
               next_osc_cnt = '0;
               next_osc_half = 1'b0;
            end
         end
         FASR_OSC_COUNT:
         begin
            next_osc_cnt = osc_cnt + 1'b1;
            if (osc_edge && osc_half)
            begin
               // Window closes on the second rising edge
               next_osc_last = next_osc_cnt;
               next_osc_fault = (next_osc_cnt < OSC_CNT_W'(OSC_LO)) ||
                                (next_osc_cnt > OSC_CNT_W'(OSC_HI));
               next_osc_cnt = '0;
               next_osc_half = 1'b0;
            end
            else if (osc_edge)
               next_osc_half = 1'b1;
            else if (osc_cnt > OSC_CNT_W'(OSC_HI))
            begin
               // A stopped oscillator never closes the window
               next_osc_last = osc_cnt;
               next_osc_fault = 1'b1;
               next_osc_state = FASR_OSC_WAIT;
            end
         end
         default:
            next_osc_state = FASR_OSC_WAIT;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         osc_state <= FASR_OSC_WAIT;
         osc_cnt <= '0;
         osc_last <= '0;
         osc_half <= 1'b0;
         osc_prev <= 1'b0;
         osc_fault <= 1'b0;
      end
      else if (ce)
      begin
         osc_state <= next_osc_state;
         osc_cnt <= next_osc_cnt;
         osc_last <= next_osc_last;
         osc_half <= next_osc_half;
         osc_prev <= slow_osc_s;
         osc_fault <= next_osc_fault;
      end
   end

   // AXI4-Lite slave
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q;
   logic bvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic rvalid_q;
   logic next_aw_held;
   logic next_w_held;
   logic [ADDR_W-1:0] next_awaddr_q;
   logic [31:0] next_wdata_q;
   logic [3:0] next_wstrb_q;
   logic [1:0] next_bresp_q;
   logic next_bvalid_q;
   logic [31:0] next_rdata_q;
   logic [1:0] next_rresp_q;
   logic next_rvalid_q;
   logic do_write;
   logic [7:0] wr_ofs;
   logic [7:0] rd_ofs;
   logic [15:0] wr_mask;
   logic alert_reset_flag;
   logic next_alert_reset_flag;
   logic [15:0] irq_mask;
   logic [15:0] next_irq_mask;
   logic wr_hit;
   logic rd_hit;

   assign s_axi_awready = ce & ~aw_held;
   assign s_axi_wready = ce & ~w_held;
   assign s_axi_arready = ce & ~rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   assign do_write = aw_held & w_held & ~bvalid_q;
   assign wr_ofs = {awaddr_q[7:2], 2'b00};
   assign rd_ofs = {s_axi_araddr[7:2], 2'b00};
   assign wr_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign wr_hit = (wr_ofs == FASR_OFS_ALERT) || (wr_ofs == FASR_OFS_CTRL) ||
                   (wr_ofs == FASR_OFS_IRQ_STATUS) || (wr_ofs == FASR_OFS_IRQ_MASK) ||
                   (wr_ofs == FASR_OFS_BALSW) || (wr_ofs == FASR_OFS_OSC_COUNT);
   assign rd_hit = (rd_ofs == FASR_OFS_ALERT) || (rd_ofs == FASR_OFS_CTRL) ||
                   (rd_ofs == FASR_OFS_IRQ_STATUS) || (rd_ofs == FASR_OFS_IRQ_MASK) ||
                   (rd_ofs == FASR_OFS_BALSW) || (rd_ofs == FASR_OFS_OSC_COUNT);

   fasr_sticky_if #(.W(FASR_ALERT_W)) alert_bits ();
   fasr_sticky_if #(.W(FASR_ALERT_W)) irq_bits ();

   always_comb
   begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_awaddr_q = awaddr_q;
      next_wdata_q = wdata_q;
      next_wstrb_q = wstrb_q;
      next_bresp_q = bresp_q;
      next_bvalid_q = bvalid_q;
      next_rdata_q = rdata_q;
      next_rresp_q = rresp_q;
      next_rvalid_q = rvalid_q;
      next_alert_reset_flag = alert_reset_flag;
      next_irq_mask = irq_mask;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_aw_held = 1'b1;
         next_awaddr_q = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_w_held = 1'b1;
         next_wdata_q = s_axi_wdata;
         next_wstrb_q = s_axi_wstrb;
      end
      if (do_write)
      begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid_q = 1'b1;
         next_bresp_q = wr_hit ? FASR_RESP_OKAY : FASR_RESP_SLVERR;
         if (wr_ofs == FASR_OFS_CTRL && wstrb_q[0])
            next_alert_reset_flag = wdata_q[FASR_BIT_ALERT_RESET];
         if (wr_ofs == FASR_OFS_IRQ_MASK)
            next_irq_mask = (irq_mask & ~wr_mask) | (wdata_q[15:0] & wr_mask);
      end
      else if (bvalid_q && s_axi_bready)
         next_bvalid_q = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_rvalid_q = 1'b1;
         next_rresp_q = rd_hit ? FASR_RESP_OKAY : FASR_RESP_SLVERR;
         case (rd_ofs)
            FASR_OFS_ALERT: next_rdata_q = {16'h0000, alert_bits.q};
            FASR_OFS_CTRL: next_rdata_q = {31'h0000_0000, alert_reset_flag};
            FASR_OFS_IRQ_STATUS: next_rdata_q = {16'h0000, irq_bits.q};
            FASR_OFS_IRQ_MASK: next_rdata_q = {16'h0000, irq_mask};
            FASR_OFS_BALSW: next_rdata_q = {18'h0_0000, balance_switch_fault};
            FASR_OFS_OSC_COUNT: next_rdata_q = 32'(osc_last);
            default: next_rdata_q = 32'h0000_0000;
         endcase
      end
      else if (rvalid_q && s_axi_rready)
         next_rvalid_q = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bresp_q <= FASR_RESP_OKAY;
         bvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= FASR_RESP_OKAY;
         rvalid_q <= 1'b0;
         alert_reset_flag <= FASR_ALERT_RESET_FLAG_RESET_VAL;
         irq_mask <= FASR_IRQ_MASK_RESET_VAL;
      end
      else if (ce)
      begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         awaddr_q <= next_awaddr_q;
         wdata_q <= next_wdata_q;
         wstrb_q <= next_wstrb_q;
         bresp_q <= next_bresp_q;
         bvalid_q <= next_bvalid_q;
         rdata_q <= next_rdata_q;
         rresp_q <= next_rresp_q;
         rvalid_q <= next_rvalid_q;
         alert_reset_flag <= next_alert_reset_flag;
         irq_mask <= next_irq_mask;
      end
   end

   // Alert sources and clears
   logic balsw_any;
   logic gate_open;
   logic [15:0] zero_clear;

   assign balsw_any = |balance_switch_fault;
   assign gate_open = ~alert_reset_flag;
   // Only a zero in a strobed, clearable lane clears a bit
   assign zero_clear = (do_write && wr_ofs == FASR_OFS_ALERT) ?
                       (wr_mask & ~wdata_q[15:0] & FASR_ALERT_W0C_MASK) : 16'h0000;

   always_comb
   begin
      alert_bits.set = '0;
      alert_bits.set[FASR_BIT_SLOW_OSC] = osc_fault;
      alert_bits.set[FASR_BIT_SLOW_OSC_RED] = osc_fault;
      alert_bits.set[FASR_BIT_UPPER_SE] = upper_se_s & gate_open;
      alert_bits.set[FASR_BIT_LOWER_SE] = lower_se_s & gate_open;
      alert_bits.set[FASR_BIT_UPPER_SE_RED] = upper_se_s;
      alert_bits.set[FASR_BIT_LOWER_SE_RED] = lower_se_s;
      alert_bits.set[FASR_BIT_SUPPLY_LSB +: 3] = supply_s & {3{gate_open}};
      alert_bits.set[FASR_BIT_GROUND_LSB +: 3] = ground_s & {3{gate_open}};
      alert_bits.set[FASR_BIT_HV_UV] = hv_under_s & gate_open;
      alert_bits.set[FASR_BIT_HV_HEADROOM] = headroom_s & acq_active;
      alert_bits.set[FASR_BIT_HV_OV] = hv_over_s & gate_open;
      alert_bits.set[FASR_BIT_BALSW_SUM] = balance_switch_diag_scan_done & balsw_any;
      alert_bits.clr = zero_clear;
      // Scan with every alert resolved drops the summary
      alert_bits.clr[FASR_BIT_BALSW_SUM] = zero_clear[FASR_BIT_BALSW_SUM] |
         (balance_switch_diag_scan_done & ~balsw_any);
   end

   // Interrupt status catches each newly set alert; write one to clear
   always_comb
   begin
      irq_bits.set = alert_bits.set & ~alert_bits.q;
      irq_bits.clr = (do_write && wr_ofs == FASR_OFS_IRQ_STATUS) ?
                     (wr_mask & wdata_q[15:0]) : 16'h0000;
   end

   fasr_sticky_bank #(
      .W(FASR_ALERT_W),
      .RESET_VAL(FASR_ALERT_RESET_VAL)
   ) u_alert_bank (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .bits(alert_bits)
   );

   fasr_sticky_bank #(
      .W(FASR_ALERT_W),
      .RESET_VAL(FASR_ALERT_RESET_VAL)
   ) u_irq_bank (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .bits(irq_bits)
   );

   assign fault_alert_status_1 = alert_bits.q;
   assign irq = |(irq_bits.q & irq_mask);

endmodule

//--- sim/fasr_asserts.sv
/*
 Checker for fasr_top: bus handshakes, sticky alert bits and the
 balance summary bit, seen only through the top module's ports.
 Assumes a single aclk domain with synchronous active-low reset.
*/
`timescale 1ns/100ps
module fasr_asserts
   import fasr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic acq_active,
   input wire logic [FASR_BALSW_N-1:0] balance_switch_fault,
   input wire logic balance_switch_diag_scan_done,
   input wire logic [FASR_ALERT_W-1:0] fault_alert_status_1
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_rd_taken;
      ce && s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_scan_hit;
      ce && balance_switch_diag_scan_done && (balance_switch_fault != 14'h0000);
   endsequence
   sequence s_scan_none;
      ce && balance_switch_diag_scan_done && (balance_switch_fault == 14'h0000);
   endsequence
   a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
      else $error("read answer late");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_ready_ce: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
      else $error("ready while frozen");
   a_se_sticky: assert property ((~fault_alert_status_1[13:10] & $past(fault_alert_status_1[13:10])) == 4'h0)
      else $error("single ended bit fell");
   a_fall_by_write: assert property ((~fault_alert_status_1[15:1] & $past(fault_alert_status_1[15:1])) != 15'h0000 |-> $rose(s_axi_bvalid))
      else $error("alert bit fell without write");
   a_sum_rise: assert property ($rose(fault_alert_status_1[0]) |-> $past(balance_switch_diag_scan_done))
      else $error("summary rose without scan");
   a_sum_set: assert property (s_scan_hit |=> fault_alert_status_1[0])
      else $error("summary not set at scan end");
   a_sum_clear: assert property (s_scan_none |=> !fault_alert_status_1[0])
      else $error("summary not cleared at scan end");
   a_headroom_acq: assert property ($rose(fault_alert_status_1[2]) |-> $past(acq_active) || $past(acq_active, 2))
      else $error("headroom set outside acquisition");
endmodule
bind fasr_top fasr_asserts u_chk (.aclk, .aresetn, .ce, .s_axi_awready, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .acq_active, .balance_switch_fault,
   .balance_switch_diag_scan_done, .fault_alert_status_1);

//--- sim/fault_alert_status_register_bench.sv
/*
 Self-checking bench for fasr_top: AXI4-Lite accesses, alert inputs,
 balance scans, oscillator timing and the interrupt.
 Assumes the oscillator window shortened to 100 aclk cycles.
*/
`timescale 1ns/100ps
module fault_alert_status_register_bench;
   import fasr_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, seed = 32'hbd31_cf37;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] fault_alert_status_1;
   logic slow_osc_in = 1'b0, upper_port_single_ended = 1'b0, lower_port_single_ended = 1'b0;
   logic hv_under = 1'b0, hv_headroom_low = 1'b0, hv_over = 1'b0, acq_active = 1'b0;
   logic balance_switch_diag_scan_done = 1'b0;
   logic [2:0] low_supply_under = 3'h0, ground_open = 3'h0;
   logic [13:0] balance_switch_fault = 14'h0000;
   logic [31:0] q_data[$];
   logic [1:0] q_rresp[$], q_bresp[$];
   int n_mismatch = 0, compares = 0, osc_half = 25;
   fasr_top #(.OSC_EXPECT_CYCLES(100)) i_dut
   (
      .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .slow_osc_in, .upper_port_single_ended, .lower_port_single_ended,
      .low_supply_under, .ground_open, .hv_under, .hv_headroom_low, .hv_over, .acq_active,
      .balance_switch_fault, .balance_switch_diag_scan_done, .fault_alert_status_1, .irq
   );
   initial forever #2.5 aclk = ~aclk;
   // Slow oscillator; half period in aclk cycles
   initial forever
   begin
      repeat (osc_half) @(posedge aclk);
      slow_osc_in <= ~slow_osc_in;
   end
   initial
   begin
      repeat (10000) @(posedge aclk);
      n_mismatch++;
      wrap_up();
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk_data(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Results are paired with notes in issue order
   always @(posedge aclk)
   begin
      if (s_axi_rvalid && s_axi_rready)
      begin
         chk_data("rdata", q_data.pop_front(), s_axi_rdata);
         chk_resp("rresp", q_rresp.pop_front(), s_axi_rresp);
      end
      if (s_axi_bvalid && s_axi_bready)
         chk_resp("bresp", q_bresp.pop_front(), s_axi_bresp);
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      q_bresp.push_back(r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
      q_data.push_back(e);
      q_rresp.push_back(r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   task automatic scan(input logic [13:0] v);
      @(posedge aclk);
      balance_switch_fault <= v;
      balance_switch_diag_scan_done <= 1'b1;
      @(posedge aclk);
      balance_switch_diag_scan_done <= 1'b0;
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(FASR_OFS_ALERT, 32'h0000_0000);
      rd(FASR_OFS_CTRL, 32'h0000_0001);
      rd(8'h40, 32'h0000_0000, FASR_RESP_SLVERR);
      wr(8'h40, 32'h0000_0000, FASR_RESP_SLVERR);
      $display("test reset done");
      @(posedge aclk);
      {upper_port_single_ended, lower_port_single_ended, hv_under, hv_over} <= 4'hf;
      {low_supply_under, ground_open} <= 6'h3f;
      repeat (8) @(posedge aclk);
      rd(FASR_OFS_ALERT, 32'h0000_0c00);
      wr(FASR_OFS_CTRL, 32'h0000_0000);
      repeat (8) @(posedge aclk);
      rd(FASR_OFS_ALERT, 32'h0000_3ffa);
      wr(FASR_OFS_ALERT, 32'h0000_0000);
      rd(FASR_OFS_ALERT, 32'h0000_3ffa);
      {hv_under, hv_over, low_supply_under, ground_open} <= 8'h00;
      repeat (8) @(posedge aclk);
      wr(FASR_OFS_ALERT, rnd() | 32'h0000_ffff);
      rd(FASR_OFS_ALERT, 32'h0000_3ffa);
      wr(FASR_OFS_ALERT, 32'h0000_0000);
      rd(FASR_OFS_ALERT, 32'h0000_3c00);
      $display("test gated alerts done");
      hv_headroom_low <= 1'b1;
      repeat (8) @(posedge aclk);
      rd(FASR_OFS_ALERT, 32'h0000_3c00);
      acq_active <= 1'b1;
      repeat (4) @(posedge aclk);
      {acq_active, hv_headroom_low} <= 2'b00;
      rd(FASR_OFS_ALERT, 32'h0000_3c04);
      wr(FASR_OFS_ALERT, 32'h0000_0000);
      $display("test headroom done");
      for (int i = 0; i < 14; i++)
      begin
         scan(14'h0001 << i);
         rd(FASR_OFS_ALERT, 32'h0000_3c01);
         scan(14'h0000);
         rd(FASR_OFS_ALERT, 32'h0000_3c00);
      end
      scan(14'(rnd()) | 14'h0001);
      wr(FASR_OFS_ALERT, 32'h0000_ffff);
      rd(FASR_OFS_ALERT, 32'h0000_3c01);
      wr(FASR_OFS_ALERT, 32'h0000_0000);
      rd(FASR_OFS_ALERT, 32'h0000_3c00);
      $display("test balance done");
      wr(FASR_OFS_IRQ_STATUS, 32'h0000_ffff);
      wr(FASR_OFS_IRQ_MASK, 32'h0000_8000);
      chk_bit("irq", 1'b0, irq);
      // Window of 140 cycles lies outside 95..105
      osc_half = 35;
      repeat (500) @(posedge aclk);
      wr(FASR_OFS_ALERT, 32'h0000_0000);
      rd(FASR_OFS_ALERT, 32'h0000_fc00);
      chk_bit("irq", 1'b1, irq);
      wr(FASR_OFS_IRQ_MASK, 32'h0000_0000);
      chk_bit("irq", 1'b0, irq);
      wr(FASR_OFS_IRQ_MASK, 32'h0000_8000);
      chk_bit("irq", 1'b1, irq);
      osc_half = 25;
      repeat (500) @(posedge aclk);
      wr(FASR_OFS_IRQ_STATUS, 32'h0000_8000);
      chk_bit("irq", 1'b0, irq);
      wr(FASR_OFS_ALERT, 32'h0000_0000);
      rd(FASR_OFS_ALERT, 32'h0000_3c00);
      rd(FASR_OFS_OSC_COUNT, 32'h0000_0064);
      chk_data("status", 32'h0000_3c00, 32'(fault_alert_status_1));
      $display("test oscillator done");
      ce <= 1'b0;
      repeat (3) @(posedge aclk);
      ce <= 1'b1;
      rd(FASR_OFS_ALERT, 32'h0000_3c00);
      wrap_up();
   end
endmodule
